// *** hdl/lfi_cfg.svh ***
//
// Behaviour
// [RL1] table values are unsigned ten bit
// [RL2] internal path fourteen bits, rounded
// [RL3] output sixteen bits, no rounding
// [RL4] straight-line interpolation, equal intervals, positive only
// [RL5] one-variable function within 120 microseconds
// [RL6] argument takes top fourteen bits after grant
// [RL7] instruction is flag plus ten bits
// [RL8] word meaning follows position in band
// [RL9] index 0-3 added to chosen addresses
// [RL10] table word is flag plus magnitude
// [RL11] nine points, curves, pages per variable
// [RL12] argument: sign, interval, increment
// [RL13] three argument registers X, Y, Z
// [RL14] negative argument forced to zero
// [RL15] argument address from address instruction
// [RL16] fixed sequence paced by memory grants; the code paces it by drum words and flags a late argument read
// [RL17] only data memory reads and writes
// [RL18] whole field of words every 0.1 s
// [RL19] interpolator waits behind main processing
// [RL20] four bands of eleven-bit words
// [RL21] lower point plus increment times difference
`ifndef LFI_CFG_SVH
`define LFI_CFG_SVH

// ==========================================================
// word formats
`define LFI_DRUM_W 11
`define LFI_FLAG_BIT 10
`define LFI_FIELD_W 10
`define LFI_MEM_W 24
`define LFI_ADDR_W 11
`define LFI_ARG_SIGN 23
`define LFI_ARG_MSB 22
`define LFI_ARG_LSB 10
`define LFI_RES_LSB 8
`define LFI_PT_PAD 4'h0

// ==========================================================
// control word fields
`define LFI_CW_NVAR_MSB 1
`define LFI_CW_EN_LSB 2
`define LFI_CW_EN_MSB 5
`define LFI_CW_IDX_LSB 6
`define LFI_CW_IDX_MSB 7

// ==========================================================
// table and timing
`define LFI_TBL_LAST 4'h8
`define LFI_FINAL_1 3'h0
`define LFI_FINAL_2 3'h4
`define LFI_FINAL_3 3'h6
`define LFI_CLK_MHZ 20
`define LFI_PROC_US 120
`define LFI_PROC_CYC (`LFI_PROC_US * `LFI_CLK_MHZ)
`define LFI_FIELD_WORDS 16344
`define LFI_BANDS 4

`endif

// *** hdl/lfi_interp.sv ***
`timescale 1ns/1ps
`include "lfi_cfg.svh"
module lfi_interp import lfi_pkg::*; #(
    parameter int FIELD_WORDS = `LFI_FIELD_WORDS
) (
    // clock, reset and freeze
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // drum band read heads
    input wire logic [10:0] drum_word,
    input wire logic drum_strobe,
    // shared data memory, second priority
    output logic mem_req,
    input wire logic mem_gnt,
    output logic mem_we,
    output logic [10:0] mem_addr,
    input wire logic [23:0] mem_rdata,
    output logic [23:0] mem_wdata,
    // status
    output logic result_valid,
    output logic exec_fail,
    output logic field_tick
);

    // ==========================================================
    // helpers

    // a + f*(b-a) in 16 bit units, truncated (no roundoff)
    function automatic logic [15:0] lfi_lerp(input logic [13:0] a,
        input logic [13:0] b, input logic [9:0] f);
        logic signed [14:0] d;
        logic signed [25:0] p;
        d = $signed({1'b0, b}) - $signed({1'b0, a});
        p = d * $signed({1'b0, f});
        lfi_lerp = {a, 2'h0} + p[23:8];
    endfunction

    // round 16 bit back to the 14 bit internal path
    function automatic logic [13:0] lfi_round(input logic [15:0] r);
        logic [16:0] t;
        t = {1'b0, r} + 17'h00002;
        lfi_round = t[15:2];
    endfunction

    // {point used, upper point} for a counter against an interval
    function automatic logic [1:0] lfi_hit(input logic [3:0] c,
        input logic [2:0] iv);
        logic [3:0] lo;
        lo = {1'b0, iv};
        lfi_hit = {(c == lo) || (c == lo + 4'h1), c == lo + 4'h1};
    endfunction

    // optional index counter offset on an address
    function automatic logic [9:0] lfi_index(input logic [9:0] a,
        input logic en, input logic [1:0] v);
        lfi_index = en ? a + {8'h00, v} : a;
    endfunction

    // ==========================================================
    // state

    lfi_state_struct_type st; // registered state
    lfi_state_struct_type nx; // next state
    logic word_evt; // new drum word, from synchronised strobe
    logic flag; // flag bit of the drum word
    logic [9:0] field; // ten bit part of the drum word
    logic [1:0] hx, hy, hz; // point hits per axis
    logic cap_hit; // data word is a needed corner point
    logic [2:0] cap_slot; // which corner it fills
    logic [12:0] rd_arg; // argument bits from the memory word
    logic [2:0] fin_stage; // last compute stage for this form

    assign word_evt = st.s2_stb && !st.stb_prev;
    assign flag = st.s2_word[`LFI_FLAG_BIT]; // see [RL7]
    assign field = st.s2_word[9:0];
    assign hx = lfi_hit(st.ci, st.ax[0][12:10]);
    assign hy = lfi_hit(st.cj, st.ax[1][12:10]);
    assign hz = lfi_hit(st.ck, st.ax[2][12:10]);
    assign cap_hit = hx[1] && hy[1] && hz[1]; // see [RL11]
    assign cap_slot = {hz[0], hy[0], hx[0]};
    assign rd_arg = mem_rdata[`LFI_ARG_MSB:`LFI_ARG_LSB]; // see [RL6]
    assign fin_stage = (st.nvars == 2'h1) ? `LFI_FINAL_1 :
        (st.nvars == 2'h2) ? `LFI_FINAL_2 : `LFI_FINAL_3;

    // ==========================================================
    // next state
    // one pass per function block; drum words cannot be stalled,
    // so a late argument is flagged rather than waited for
    always_comb begin
        logic last;
        logic [1:0] pi;
        logic [1:0] v;
        logic [15:0] r;
        last = 1'b0;
        pi = 2'h0;
        v = 2'h0;
        r = 16'h0000;
        nx = st;
        nx.result_valid = 1'b0;
        nx.field_tick = 1'b0;
        // two flops on the asynchronous drum heads
        nx.s1_word = drum_word;
        nx.s2_word = st.s1_word;
        nx.s1_stb = drum_strobe;
        nx.s2_stb = st.s1_stb;
        nx.stb_prev = st.s2_stb;
        // process time, saturating
        if (st.pcnt != 12'hFFF) begin
            nx.pcnt = st.pcnt + 12'h001;
        end

        // field word counter, four bands in turn
        if (word_evt) begin
            if (st.wcnt == 14'(FIELD_WORDS - 1)) begin
                nx.wcnt = 14'h0000; // see [RL18] [RL20]
                nx.field_tick = 1'b1;
            end else begin
                nx.wcnt = st.wcnt + 14'h0001;
            end
        end

        // memory port: finish the access in flight
        if (st.mreq && mem_gnt) begin // see [RL19]
            nx.mreq = 1'b0;
            if (!st.mwe) begin
                nx.pend[st.msel] = 1'b0;
                // negative argument becomes zero, sign dropped
                nx.ax[st.msel] = mem_rdata[`LFI_ARG_SIGN] ?
                    13'h0000 : rd_arg; // see [RL14] [RL12]
            end else begin
                nx.result_valid = 1'b1;
                nx.state = S_IDLE;
                if (st.nvars == 2'h1 && st.pcnt > 12'(`LFI_PROC_CYC))
                begin
                    nx.exec_fail = 1'b1; // see [RL5]
                end
            end
        end else if (!st.mreq && st.pend != 3'h0) begin
            // launch the lowest pending argument read
            v = st.pend[0] ? 2'h0 : st.pend[1] ? 2'h1 : 2'h2;
            nx.mreq = 1'b1;
            nx.mwe = 1'b0;
            nx.msel = v;
            nx.maddr = {1'b0, lfi_index(st.aaddr[v], st.idx_en[v],
                st.idx_val)}; // see [RL9] [RL15]
        end

        // band sequencer, word meaning set by position
        case (st.state)
            S_IDLE, S_ADDR, S_DATA, S_ANS: begin
                if (word_evt && flag) begin
                    // control word opens a block; any block cut short
                    // is reported as a failure
                    if (st.state != S_IDLE) begin
                        nx.exec_fail = 1'b1;
                    end else begin
                        nx.exec_fail = 1'b0;
                    end
                    nx.state = S_ADDR; // see [RL8]
                    nx.nvars = (field[1:0] == 2'h0) ? 2'h1 : field[1:0];
                    nx.idx_en = field[`LFI_CW_EN_MSB:`LFI_CW_EN_LSB];
                    nx.idx_val = field[`LFI_CW_IDX_MSB:`LFI_CW_IDX_LSB];
                    nx.acnt = 2'h0;
                    nx.pend = 3'h0;
                    nx.ax = '0; // unused axes sit at interval zero
                    nx.ci = 4'h0;
                    nx.cj = 4'h0;
                    nx.ck = 4'h0;
                    nx.pcnt = 12'h000;
                end else if (word_evt && st.state == S_ADDR) begin
                    // X, Y, Z argument address words
                    nx.aaddr[st.acnt] = field; // see [RL13] [RL15]
                    nx.pend[st.acnt] = 1'b1;
                    nx.acnt = st.acnt + 2'h1;
                    if (st.acnt + 2'h1 == st.nvars) begin
                        nx.state = S_DATA;
                    end
                end else if (word_evt && st.state == S_DATA) begin
                    // table words, magnitude positive
                    if (st.pend != 3'h0) begin
                        nx.exec_fail = 1'b1; // see [RL16]
                    end
                    if (cap_hit) begin
                        nx.pts[cap_slot] = {field, `LFI_PT_PAD};
                    end // see [RL1] [RL10]
                    last = st.ci == `LFI_TBL_LAST &&
                        (st.nvars < 2'h2 || st.cj == `LFI_TBL_LAST) &&
                        (st.nvars < 2'h3 || st.ck == `LFI_TBL_LAST);
                    if (last) begin
                        nx.state = S_ANS; // see [RL11]
                    end else if (st.ci != `LFI_TBL_LAST) begin
                        nx.ci = st.ci + 4'h1;
                    end else if (st.cj != `LFI_TBL_LAST) begin
                        nx.ci = 4'h0;
                        nx.cj = st.cj + 4'h1;
                    end else begin
                        nx.ci = 4'h0;
                        nx.cj = 4'h0;
                        nx.ck = st.ck + 4'h1;
                    end
                end else if (word_evt && st.state == S_ANS) begin
                    // answer address closes the band block
                    nx.ans_addr = lfi_index(field, st.idx_en[3],
                        st.idx_val); // see [RL9]
                    nx.stage = 3'h0;
                    nx.state = S_COMP;
                end
            end
            S_COMP: begin
                // one straight-line step per cycle: X pairs, then Y
                // pairs, then the Z pair
                if (st.stage < 3'h4) begin
                    pi = st.stage[1:0];
                    v = 2'h0;
                end else if (st.stage < 3'h6) begin
                    pi = 2'(st.stage - 3'h4);
                    v = 2'h1;
                end else begin
                    pi = 2'h0;
                    v = 2'h2;
                end
                r = lfi_lerp(st.pts[{pi, 1'b0}], st.pts[{pi, 1'b1}],
                    st.ax[v][9:0]); // see [RL21] [RL4]
                nx.interp_multiplier_reg = st.ax[v][9:0];
                nx.interp_accumulator = r;
                nx.result_reg_second = lfi_round(r); // see [RL2]
                nx.pts[pi] = lfi_round(r);
                if (st.stage == fin_stage) begin
                    // final value written unrounded
                    nx.result_reg_first = r; // see [RL3]
                    nx.mwdata = {r, 8'h00};
                    nx.state = S_WRITE;
                end else if (st.nvars == 2'h2 && st.stage == 3'h1) begin
                    nx.stage = 3'h4;
                end else begin
                    nx.stage = st.stage + 3'h1;
                end
            end
            S_WRITE: begin
                // a control word here finds the engine busy
                if (word_evt && flag) begin
                    nx.exec_fail = 1'b1;
                end
                if (!st.mreq && st.pend == 3'h0) begin
                    nx.mreq = 1'b1; // see [RL17]
                    nx.mwe = 1'b1;
                    nx.maddr = {1'b0, st.ans_addr};
                end
            end
            default: begin
                nx.state = S_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state register, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= nx;
        end
    end

    // ==========================================================
    // outputs
    assign mem_req = st.mreq;
    assign mem_we = st.mwe;
    assign mem_addr = st.maddr;
    assign mem_wdata = st.mwdata;
    assign result_valid = st.result_valid;
    assign exec_fail = st.exec_fail;
    assign field_tick = st.field_tick;

    // ==========================================================
    // checks
    // any axis: the zeroing must not depend on which argument is read
    chk_arg_neg_zero: assert property ( // see [RL14]
        @(posedge mclk) disable iff (!rst_n)
        ce && mem_gnt && st.mreq && !st.mwe && mem_rdata[`LFI_ARG_SIGN]
        |=> st.ax[$past(st.msel)] == 13'h0000)
        else $error("negative argument not zeroed");

    chk_arg_top_bits: assert property ( // see [RL6]
        @(posedge mclk) disable iff (!rst_n)
        ce && mem_gnt && st.mreq && !st.mwe && st.msel == 2'h1 &&
        !mem_rdata[`LFI_ARG_SIGN] |=> st.ax[1] == $past(rd_arg))
        else $error("argument bits not taken from word top");

    chk_req_held: assert property ( // see [RL19]
        @(posedge mclk) disable iff (!rst_n)
        st.mreq && !(ce && mem_gnt) |=> st.mreq && $stable(st.maddr))
        else $error("request dropped before grant");

    chk_write_result: assert property ( // see [RL3]
        @(posedge mclk) disable iff (!rst_n)
        st.mreq && st.mwe |-> mem_wdata[23:8] == st.result_reg_first &&
        mem_addr == {1'b0, st.ans_addr})
        else $error("written word differs from result");

    chk_field_wrap: assert property ( // see [RL18]
        @(posedge mclk) disable iff (!rst_n)
        ce && word_evt && st.wcnt == 14'(FIELD_WORDS - 1)
        |=> st.field_tick && st.wcnt == 14'h0000 ##1 !st.field_tick)
        else $error("field wrap wrong");

    chk_late_fail: assert property ( // see [RL5]
        @(posedge mclk) disable iff (!rst_n)
        ce && mem_gnt && st.mreq && st.mwe && st.nvars == 2'h1 &&
        st.pcnt > 12'(`LFI_PROC_CYC) |=> st.exec_fail && st.result_valid)
        else $error("late one-variable result not flagged");

    chk_stale_arg: assert property ( // see [RL16]
        @(posedge mclk) disable iff (!rst_n)
        ce && word_evt && !flag && st.state == S_DATA && st.pend != 3'h0
        |=> st.exec_fail)
        else $error("data before argument not flagged");

    chk_point_store: assert property ( // see [RL10]
        @(posedge mclk) disable iff (!rst_n)
        ce && word_evt && !flag && st.state == S_DATA && cap_hit &&
        cap_slot == 3'h0 |=> st.pts[0] == {$past(field), `LFI_PT_PAD})
        else $error("lower table point not captured");

    // a stretched pulse would be counted twice by the main program
    chk_result_pulse: assert property ( // see [RL17]
        @(posedge mclk) disable iff (!rst_n)
        ce && st.result_valid |=> !st.result_valid)
        else $error("result pulse longer than one cycle");

    chk_read_launch: assert property ( // see [RL16]
        @(posedge mclk) disable iff (!rst_n)
        ce && !st.mreq && st.pend[0] |=> st.mreq && !st.mwe &&
        st.msel == 2'h0)
        else $error("pending X argument read not launched");

    chk_final_write: assert property ( // see [RL3]
        @(posedge mclk) disable iff (!rst_n)
        ce && st.state == S_COMP && st.stage == fin_stage
        |=> st.state == S_WRITE && st.mwdata[7:0] == 8'h00)
        else $error("final stage did not stage the write");

    chk_write_launch: assert property ( // see [RL17]
        @(posedge mclk) disable iff (!rst_n)
        ce && st.state == S_WRITE && !st.mreq && st.pend == 3'h0
        |=> st.mreq && st.mwe)
        else $error("answer write not requested");

endmodule // lfi_interp

// *** hdl/lfi_pkg.sv ***
// ==========================================================
// types of the interpolator
package lfi_pkg;
`include "lfi_cfg.svh"

    // band sequencer states
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_DATA, S_ANS, S_COMP, S_WRITE
    } lfi_state_type;

    // whole register state of the engine
    typedef struct packed {
        lfi_state_type state;
        logic [10:0] s1_word;
        logic [10:0] s2_word;
        logic s1_stb;
        logic s2_stb;
        logic stb_prev;
        logic [1:0] nvars;
        logic [3:0] idx_en;
        logic [1:0] idx_val;
        logic [1:0] acnt;
        logic [2:0][9:0] aaddr;
        logic [2:0] pend;
        logic [2:0][12:0] ax;
        logic [3:0] ci;
        logic [3:0] cj;
        logic [3:0] ck;
        logic [7:0][13:0] pts;
        logic [2:0] stage;
        logic [9:0] ans_addr;
        logic [15:0] interp_accumulator;
        logic [9:0] interp_multiplier_reg;
        logic [15:0] result_reg_first;
        logic [13:0] result_reg_second;
        logic mreq;
        logic mwe;
        logic [1:0] msel;
        logic [10:0] maddr;
        logic [23:0] mwdata;
        logic result_valid;
        logic exec_fail;
        logic field_tick;
        logic [13:0] wcnt;
        logic [11:0] pcnt;
    } lfi_state_struct_type;
endpackage

// *** verif/lfi_mem_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// data memory seen through the priority arbiter
module lfi_mem_model (
    // clock
    input wire logic mclk,
    // requester side
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [10:0] mem_addr,
    input wire logic [23:0] mem_wdata,
    output logic mem_gnt,
    output logic [23:0] mem_rdata,
    // cycles lost to the main processor, set by the bench
    input wire logic [3:0] gnt_delay
);
    logic [23:0] mem [0:2047]; // core words
    logic [3:0] wait_cnt; // cycles the request has waited
    initial begin
        mem_gnt = 1'b0;
        mem_rdata = 24'h000000;
        wait_cnt = 4'h0;
    end
    // ==========================================================
    // grant only after the first-priority slots, off the edge
    always @(negedge mclk) begin
        if (mem_req && !mem_gnt && wait_cnt >= gnt_delay) begin
            mem_gnt <= 1'b1;
            mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr];
        end else begin
            // idle bus toggles so stale data never looks valid
            mem_gnt <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
        wait_cnt <= (mem_req && !mem_gnt) ? wait_cnt + 4'h1 : 4'h0;
    end
    // a write lands at its granting edge
    always @(posedge mclk) begin
        if (mem_req && mem_gnt && mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule // lfi_mem_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`include "lfi_cfg.svh"
// ==========================================================
// self-checking bench of the interpolator
module testbench;
    logic mclk, rst_n, ce, drum_strobe; // clock and drum controls
    logic [10:0] drum_word; // word under the heads
    logic mem_req, mem_gnt, mem_we; // memory handshake
    logic result_valid, exec_fail, field_tick; // status
    logic [10:0] mem_addr, wr_addr; // bus address, last write address
    logic [23:0] mem_rdata, mem_wdata, wr_data; // bus data, last write
    logic [10:0] rd_q [$]; // read addresses in order
    logic [3:0] gnt_delay; // partner grant latency
    int n_errors, comparisons, cyc, n_rv, n_tick, n_words, took, ans_gap;
    int kk [3]; // interval per variable
    int inc [3]; // increment per variable, multiples of 256
    // ==========================================================
    // instances; a short field keeps the wrap in reach
    lfi_interp #(.FIELD_WORDS(20)) dut_u (.mclk(mclk), .rst_n(rst_n),
        .ce(ce), .drum_word(drum_word), .drum_strobe(drum_strobe),
        .mem_req(mem_req), .mem_gnt(mem_gnt), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_wdata(mem_wdata), .result_valid(result_valid),
        .exec_fail(exec_fail), .field_tick(field_tick));
    lfi_mem_model mem_u (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_gnt(mem_gnt),
        .mem_rdata(mem_rdata), .gnt_delay(gnt_delay));
    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // ==========================================================
    // monitor: bus accesses, pulses and the hang limit
    always @(posedge mclk) begin
        cyc++;
        if (mem_req && mem_gnt) begin
            if (mem_we) begin
                wr_addr = mem_addr;
                wr_data = mem_wdata;
            end else begin
                rd_q.push_back(mem_addr);
            end
        end
        if (result_valid) n_rv++;
        if (field_tick) n_tick++;
        if (cyc > 40000) begin
            n_errors++;
            $display("[ERR] %0t run hung", $time);
            finish_test();
        end
    end
    // ==========================================================
    // shared tasks
    task automatic check_val(input logic [23:0] got,
            input logic [23:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // word held 4 cycles round the strobe rise, strobe low 4 after
    task automatic drum_put(input logic flag, input logic [9:0] field);
        drum_word = {flag, field};
        repeat (4) @(negedge mclk);
        drum_strobe = 1'b1;
        n_words++;
        repeat (4) @(negedge mclk);
        drum_strobe = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    // whole block; table is linear in each index so the exact
    // multilinear value needs no rounding guesswork
    task automatic run_block(input logic [1:0] nv, input logic [3:0] en,
            input logic [1:0] iv, input logic [2:0] neg);
        int n, t0, rv0, base, frac, span;
        logic [9:0] a;
        rd_q.delete();
        rv0 = n_rv;
        base = 100;
        frac = 0;
        span = (nv == 2'h1) ? 9 : (nv == 2'h2) ? 81 : 729;
        t0 = cyc;
        drum_put(1'b1, {2'b00, iv, en, nv});
        for (int v = 0; v < int'(nv); v++) begin
            a = 10'(256 + v * 16);
            // low ten bits are junk: only the top fourteen count
            mem_u.mem[{1'b0, a + (en[v] ? 10'(iv) : 10'h000)}] =
                {neg[v], 3'(kk[v]), 10'(inc[v]), 10'h3FF};
            if (!neg[v]) begin
                base += (40 - 8 * v) * kk[v];
                frac += (40 - 8 * v) * inc[v];
            end
            drum_put(1'b0, a);
        end
        for (n = 0; n < span; n++) begin
            drum_put(1'b0, 10'(100 + 40 * (n % 9) + 32 * ((n / 9) % 9)
                + 24 * (n / 81)));
        end
        // optional hold-back of the answer word, for the time limit
        repeat (ans_gap) @(negedge mclk);
        drum_put(1'b0, 10'h200);
        for (n = 0; n < 3000 && n_rv == rv0; n++) @(negedge mclk);
        took = cyc - t0;
        check_val(24'(n_rv - rv0), 24'h1, "result pulses");
        check_val(24'(rd_q.size()), 24'(nv), "reads");
        for (int v = 0; v < int'(nv); v++) begin
            check_val({13'h0, rd_q[v]}, {14'h0, 10'(256 + v * 16)
                + (en[v] ? 10'(iv) : 10'h000)}, "arg addr");
        end
        check_val({13'h0, wr_addr}, {14'h0, 10'h200
            + (en[3] ? 10'(iv) : 10'h000)}, "answer addr");
        check_val(wr_data, {16'(64 * base + frac / 16), 8'h00},
            "result");
    endtask
    // ==========================================================
    // scenarios
    // one variable, top interval, prompt grants, time limit
    task automatic sc_one();
        gnt_delay = 4'h0;
        kk[0] = 7;
        inc[0] = 768;
        run_block(2'h1, 4'h0, 2'h0, 3'b000);
        check_val(24'(took <= `LFI_PROC_CYC), 24'h1, "time");
        check_val({23'h0, exec_fail}, 24'h0, "fail flag");
    endtask
    // two variables, slow grants, freeze while idle
    task automatic sc_two();
        ce = 1'b0;
        repeat (6) @(negedge mclk);
        check_val({23'h0, mem_req}, 24'h0, "frozen req");
        ce = 1'b1;
        gnt_delay = 4'h6;
        kk[0] = 3;
        inc[0] = 256;
        kk[1] = 5;
        inc[1] = 512;
        run_block(2'h2, 4'b1001, 2'h3, 3'b000);
    endtask
    // three variables, negative Z argument forced to zero
    task automatic sc_three();
        gnt_delay = 4'h2;
        kk[0] = 1;
        inc[0] = 512;
        kk[1] = 6;
        inc[1] = 0;
        kk[2] = 4;
        inc[2] = 256;
        run_block(2'h3, 4'b0110, 2'h2, 3'b100);
    endtask
    // control word mid-block restarts and flags the failure; then a
    // block too slow for the time limit, and one whose argument grant
    // comes after the first table word
    task automatic sc_abort();
        gnt_delay = 4'h0;
        drum_put(1'b1, 10'h001);
        drum_put(1'b0, 10'h100);
        drum_put(1'b0, 10'h050);
        kk[0] = 0;
        inc[0] = 256;
        run_block(2'h1, 4'h0, 2'h0, 3'b000);
        check_val({23'h0, exec_fail}, 24'h1, "fail set");
        ans_gap = `LFI_PROC_CYC;
        kk[0] = 7;
        inc[0] = 768;
        run_block(2'h1, 4'h0, 2'h0, 3'b000);
        ans_gap = 0;
        check_val({23'h0, exec_fail}, 24'h1, "late flag");
        gnt_delay = 4'hF;
        run_block(2'h1, 4'h0, 2'h0, 3'b000);
        check_val({23'h0, exec_fail}, 24'h1, "stale flag");
        sc_one();
    endtask
    // ==========================================================
    // closing report
    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        drum_strobe = 1'b0;
        drum_word = 11'h000;
        gnt_delay = 4'h0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        sc_one();
        sc_two();
        sc_three();
        sc_abort();
        check_val(24'(n_tick), 24'(n_words / 20), "field ticks");
        finish_test();
    end
endmodule // testbench
